// File: bench/bmfc_ctrl_asserts.sv
// Concurrent checks on the ports of the buck mode and fault controller
`timescale 1ns/10ps
module bmfc_ctrl_asserts (
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  input  wire logic       i_en_above_disable,
  input  wire logic       i_fb_over,
  input  wire logic       o_hs_gate,
  input  wire logic       o_ls_gate,
  input  wire logic       o_ref_en,
  input  wire logic       o_power_good_out,
  input  wire logic       o_transient_boost,
  input  wire logic       o_forced_continuous_mode,
  input  wire logic       o_tre_en,
  input  wire logic       o_oc_default_sel,
  input  wire logic [9:0] o_overcurrent_sense_threshold,
  input  wire logic       o_fault_oc,
  input  wire logic       o_fault_ov,
  input  wire logic       o_fault_uv,
  input  wire logic       o_temp_shutdown
);
  logic [9:0] ov_cnt_q, ov_cnt_d, bst_cnt_q, bst_cnt_d;
  logic       any_fault;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  // Saturating run lengths of the overvoltage input and the boost flag
  always_comb
  begin
    ov_cnt_d  = i_fb_over ? ov_cnt_q + {9'h000, ov_cnt_q != 10'h3FF} : 10'h000;
    bst_cnt_d = o_transient_boost ? bst_cnt_q + {9'h000, bst_cnt_q != 10'h3FF} : 10'h000;
    any_fault = o_fault_oc | o_fault_ov | o_fault_uv | o_temp_shutdown;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ov_cnt_q  <= 10'h000;
      bst_cnt_q <= 10'h000;
    end
    else
    begin
      ov_cnt_q  <= ov_cnt_d;
      bst_cnt_q <= bst_cnt_d;
    end
  end

  sequence held_two(f);
    f ##1 f;
  endsequence

  sequence en_gone;
    !i_en_above_disable [*6];
  endsequence

  // Gates are registered one edge behind the mode, so the mode must have held for two samples
  forced_continuous_mode_compl_a: assert property (o_forced_continuous_mode && $past(o_forced_continuous_mode)
    |-> o_ls_gate == !o_hs_gate)
    else $error("low side is not the complement of high side");
  disable_off_a: assert property (en_gone |-> !o_hs_gate && !o_ls_gate && !o_power_good_out)
    else $error("switching continues while disabled");
  oc_latch_a: assert property (held_two(o_fault_oc) |-> !o_hs_gate && !o_ls_gate)
    else $error("gates active under overcurrent fault");
  ov_hs_off_a: assert property (held_two(o_fault_ov) |-> !o_hs_gate)
    else $error("high side on under overvoltage fault");
  uv_latch_a: assert property (held_two(o_fault_uv) |-> !o_hs_gate && !o_ls_gate)
    else $error("gates active under undervoltage fault");
  temp_off_a: assert property (o_temp_shutdown [*3] |-> !o_hs_gate && !o_ls_gate)
    else $error("gates active in thermal shutdown");
  power_good_out_fault_a: assert property (any_fault |=> !o_power_good_out)
    else $error("power good high with a fault");
  fault_clear_a: assert property ($fell(o_fault_oc) || $fell(o_fault_ov) || $fell(o_fault_uv)
    |-> !o_ref_en)
    else $error("fault cleared while enabled");
  ov_blank_a: assert property ($rose(o_fault_ov) |-> ov_cnt_q >= 10'h12C)
    else $error("overvoltage fault before blanking ended");
  boost_len_a: assert property ($fell(o_transient_boost) |-> bst_cnt_q == 10'h190)
    else $error("boost flag length wrong");
  boost_en_a: assert property ($rose(o_transient_boost) |-> o_tre_en)
    else $error("boost raised while disabled by strap");
  oc_thresh_a: assert property ($stable(o_oc_default_sel) |->
    o_overcurrent_sense_threshold == (o_oc_default_sel ? 10'h028 : 10'h000))
    else $error("overcurrent threshold does not follow selection");
endmodule

bind bmfc_ctrl bmfc_ctrl_asserts i_bmfc_ctrl_asserts (.i_mclk, .i_arst_n, .i_en_above_disable,
  .i_fb_over, .o_hs_gate, .o_ls_gate, .o_ref_en, .o_power_good_out, .o_transient_boost,
  .o_forced_continuous_mode, .o_tre_en, .o_oc_default_sel, .o_overcurrent_sense_threshold,
  .o_fault_oc, .o_fault_ov, .o_fault_uv, .o_temp_shutdown);

// File: bench/bmfc_ctrl_tb.sv
// Self-checking bench for the buck mode and fault controller
`timescale 1ns/10ps
module bmfc_ctrl_tb;
  logic       i_mclk = 1'b0, i_arst_n = 1'b0, en = 1'b0, skip = 1'b0, uvlo = 1'b0;
  logic       ref_rdy = 1'b0, ovl = 1'b0, fb_ov = 1'b0, blo = 1'b0, ahi = 1'b0, comp = 1'b0;
  logic       hot = 1'b0, cool = 1'b0, light = 1'b0, ocz = 1'b1, seen;
  logic [1:0] strap = 2'h0;
  logic [8:0] on_t = 9'h0C8;
  logic       hs, ls, ref_en, uvm_en, sup_good, pg, boost, fcm, ss, tre_en, ocsel;
  logic       ocf, ovf, uvf, tsd, oc_trip, zc;
  logic [9:0] transient_boost_threshold, oc_th;
  int         bad_count = 0, cmp_count = 0;

  always #2.5 i_mclk = ~i_mclk;

  bmfc_ctrl #(.SS_CYC(50)) i_bmfc_ctrl (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_en_above_disable(en), .i_en_above_power_saving(skip), .i_vcc_uvlo(uvlo),
    .i_ref_ready(ref_rdy), .i_oc_trip(oc_trip), .i_fb_over(fb_ov), .i_fb_below_uv_lo(blo),
    .i_fb_above_uv_hi(ahi), .i_comp_over_tre(comp), .i_temp_hot(hot), .i_temp_cool(cool),
    .i_zero_cross(zc), .i_light_load(light), .i_tre_strap(strap), .i_ocp_strap_zero(ocz),
    .i_on_time(on_t), .o_hs_gate(hs), .o_ls_gate(ls), .o_ref_en(ref_en),
    .o_uv_monitor_en(uvm_en), .o_supply_good(sup_good), .o_power_good_out(pg),
    .o_transient_boost(boost), .o_forced_continuous_mode(fcm), .o_soft_start(ss),
    .o_tre_en(tre_en), .o_transient_boost_threshold(transient_boost_threshold), .o_oc_default_sel(ocsel),
    .o_overcurrent_sense_threshold(oc_th), .o_fault_oc(ocf), .o_fault_ov(ovf),
    .o_fault_uv(uvf), .o_temp_shutdown(tsd));

  bmfc_power_stage i_bmfc_power_stage (.i_hs_gate(hs), .i_ls_gate(ls), .i_overload(ovl),
    .i_light(light), .o_oc_trip(oc_trip), .o_zero_cross(zc));

  task automatic chk(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic power_up(input logic s, input logic [1:0] st);
    skip <= s;
    strap <= st;
    en <= 1'b1;
    ref_rdy <= 1'b1;
    cyc(8);
    chk(ref_en, 1'b1, "reference off after enable");
    chk(uvm_en & sup_good, 1'b1, "supply monitor not good");
    for (int k = 0; k < 2200 && ss !== 1'b1; k++) cyc(1);
    cyc(2);
    chk(ss, 1'b1, "soft-start flag missing");
    chk(fcm, 1'b1, "soft-start not in forced mode");
    for (int k = 0; k < 200 && pg !== 1'b1; k++) cyc(1);
    cyc(2);
    chk(pg, 1'b1, "power good missing");
    chk(fcm, !s, "mode decode wrong");
  endtask

  task automatic power_down();
    en <= 1'b0;
    cyc(8);
    chk(hs | ls | pg | ref_en, 1'b0, "still active when disabled");
    chk(ocf | ovf | uvf, 1'b0, "fault kept over enable toggle");
  endtask

  task automatic t_modes();
    power_up(1'b0, 2'h0);
    chk(oc_th === 10'h028 && transient_boost_threshold === 10'h12C && tre_en, 1'b1, "default thresholds");
    chk(ocsel, 1'b1, "default overcurrent selection missing");
    power_down();
    ocz <= 1'b0;
    power_up(1'b1, 2'h0);
    chk(ocsel | (oc_th !== 10'h000), 1'b0, "programmed overcurrent threshold");
    ocz <= 1'b1;
    light <= 1'b1;
    // The period already under way still carries its pulse; skipping starts at the next wrap
    cyc(400);
    seen = 1'b0;
    repeat (900) begin cyc(1); seen |= hs; end
    chk(seen, 1'b0, "pulse not skipped at light load");
    light <= 1'b0;
    power_down();
  endtask

  task automatic t_oc();
    power_up(1'b0, 2'h0);
    for (int k = 0; k < 500 && hs !== 1'b1; k++) cyc(1);
    ovl <= 1'b1;
    cyc(5);
    chk(hs, 1'b0, "high side not cut");
    cyc(5600);
    chk(ocf, 1'b0, "overcurrent latched early");
    for (int k = 0; k < 1600 && ocf !== 1'b1; k++) cyc(1);
    cyc(3);
    chk(ocf & !hs & !ls & !pg, 1'b1, "overcurrent latch");
    ovl <= 1'b0;
    cyc(900);
    chk(ocf, 1'b1, "fault cleared without enable");
    power_down();
  endtask

  task automatic t_ov();
    power_up(1'b0, 2'h0);
    fb_ov <= 1'b1;
    cyc(250);
    chk(ovf, 1'b0, "overvoltage inside blanking");
    cyc(100);
    chk(ovf & !hs & ls, 1'b1, "overvoltage response");
    fb_ov <= 1'b0;
    blo <= 1'b1;
    cyc(6);
    chk(ls, 1'b0, "low side on below lower level");
    blo <= 1'b0;
    ahi <= 1'b1;
    cyc(6);
    chk(ls, 1'b1, "low side off above upper level");
    ahi <= 1'b0;
    power_down();
  endtask

  task automatic t_uv();
    power_up(1'b0, 2'h0);
    blo <= 1'b1;
    cyc(2800);
    chk(uvf, 1'b0, "undervoltage latched early");
    for (int k = 0; k < 900 && uvf !== 1'b1; k++) cyc(1);
    cyc(3);
    chk(uvf & !hs & !ls, 1'b1, "undervoltage latch");
    blo <= 1'b0;
    power_down();
  endtask

  task automatic t_env();
    power_up(1'b0, 2'h0);
    hot <= 1'b1;
    cyc(6);
    chk(tsd & !hs & !ls, 1'b1, "no thermal shutdown");
    hot <= 1'b0;
    cyc(6);
    chk(tsd, 1'b1, "resumed before cooling");
    cool <= 1'b1;
    cyc(6);
    chk(tsd, 1'b0, "shutdown kept after cooling");
    cool <= 1'b0;
    for (int k = 0; k < 2400 && pg !== 1'b1; k++) cyc(1);
    chk(pg, 1'b1, "no restart after cooling");
    uvlo <= 1'b1;
    cyc(6);
    chk(sup_good | pg | hs | ls, 1'b0, "running under lockout");
    uvlo <= 1'b0;
    for (int k = 0; k < 2400 && pg !== 1'b1; k++) cyc(1);
    chk(pg, 1'b1, "no restart after lockout");
    power_down();
  endtask

  task automatic t_boost(input logic [1:0] st);
    power_up(1'b0, st);
    chk(tre_en, st != 2'h2, "boost enable from strap");
    comp <= 1'b1;
    cyc(3);
    comp <= 1'b0;
    cyc(8);
    chk(boost, st != 2'h2, "boost flag start");
    cyc(300);
    chk(boost, st != 2'h2, "boost flag too short");
    cyc(120);
    chk(boost, 1'b0, "boost flag too long");
    if (st == 2'h1) chk(transient_boost_threshold === 10'h1F4, 1'b1, "alternate threshold");
    power_down();
  endtask

  initial
  begin
    cyc(16);
    i_arst_n <= 1'b1;
    chk(transient_boost_threshold === 10'h12C && oc_th === 10'h000 && !hs && !ls, 1'b1, "reset values");
    t_modes();
    t_oc();
    t_ov();
    t_uv();
    t_env();
    t_boost(2'h1);
    t_boost(2'h2);
    wrap_up();
  end

  initial
  begin
    #400000;
    bad_count++;
    wrap_up();
  end
endmodule

// File: bench/bmfc_power_stage.sv
// Behavioural switch stage and inductor facing the gate commands
`timescale 1ns/10ps
module bmfc_power_stage (
  input  wire logic i_hs_gate,
  input  wire logic i_ls_gate,
  input  wire logic i_overload,
  input  wire logic i_light,
  output logic      o_oc_trip,
  output logic      o_zero_cross
);
  // Current passes the limit only while the high side conducts
  always_comb
  begin
    o_oc_trip    = i_hs_gate & i_overload;
    o_zero_cross = i_ls_gate & i_light;
  end
endmodule

// File: logic/bmfc_ctrl.sv
// Mode decode, sequencing, gate commands and protection of the buck controller
`timescale 1ns/10ps
module bmfc_ctrl #(
  parameter int unsigned SS_CYC = bmfc_pkg::SS_CYC
) (
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  input  wire logic       i_en_above_disable,
  input  wire logic       i_en_above_power_saving,
  input  wire logic       i_vcc_uvlo,
  input  wire logic       i_ref_ready,
  input  wire logic       i_oc_trip,
  input  wire logic       i_fb_over,
  input  wire logic       i_fb_below_uv_lo,
  input  wire logic       i_fb_above_uv_hi,
  input  wire logic       i_comp_over_tre,
  input  wire logic       i_temp_hot,
  input  wire logic       i_temp_cool,
  input  wire logic       i_zero_cross,
  input  wire logic       i_light_load,
  input  wire logic [1:0] i_tre_strap,
  input  wire logic       i_ocp_strap_zero,
  input  wire logic [8:0] i_on_time,
  output logic            o_hs_gate,
  output logic            o_ls_gate,
  output logic            o_ref_en,
  output logic            o_uv_monitor_en,
  output logic            o_supply_good,
  output logic            o_power_good_out,
  output logic            o_transient_boost,
  output logic            o_forced_continuous_mode,
  output logic            o_soft_start,
  output logic            o_tre_en,
  output logic      [9:0] o_transient_boost_threshold,
  output logic            o_oc_default_sel,
  output logic      [9:0] o_overcurrent_sense_threshold,
  output logic            o_fault_oc,
  output logic            o_fault_ov,
  output logic            o_fault_uv,
  output logic            o_temp_shutdown
);
  localparam int unsigned W = bmfc_pkg::SY_W;

  function automatic logic [8:0] sat_inc(input logic [8:0] v);
    sat_inc = (v == 9'h1FF) ? v : v + 9'h001;
  endfunction

  // Two-flop synchroniser for every pin input except i_on_time
  logic [W-1:0] sy1_q;
  logic [W-1:0] sy_q;

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sy1_q <= '0;
      sy_q  <= '0;
    end
    else
    begin
      sy1_q <= {i_ocp_strap_zero, i_tre_strap, i_light_load, i_zero_cross, i_temp_cool,
                i_temp_hot, i_comp_over_tre, i_fb_above_uv_hi, i_fb_below_uv_lo, i_fb_over,
                i_oc_trip, i_ref_ready, i_vcc_uvlo, i_en_above_power_saving,
                i_en_above_disable};
      sy_q  <= sy1_q;
    end
  end

  logic en_on;
  logic mode_ps;
  logic uvlo;
  assign en_on   = sy_q[bmfc_pkg::SY_EN_DIS];
  assign mode_ps = en_on && sy_q[bmfc_pkg::SY_EN_SKIP];
  assign uvlo    = sy_q[bmfc_pkg::SY_UVLO];

  // Sequencer
  bmfc_pkg::bmfc_state_t state_q;
  bmfc_pkg::bmfc_state_t state_d;
  logic [17:0]           tmr_q;
  logic [17:0]           tmr_d;
  logic [1:0]            tre_sel_q;
  logic [1:0]            tre_sel_d;
  logic                  oc_zero_q;
  logic                  oc_zero_d;
  logic                  ot_q;
  logic                  ot_d;
  logic                  fault_any;
  logic                  hold;

  assign hold = uvlo || ot_q;

  always_comb
  begin
    state_d   = state_q;
    tmr_d     = tmr_q;
    tre_sel_d = tre_sel_q;
    oc_zero_d = oc_zero_q;
    ot_d      = ot_q;
    if (sy_q[bmfc_pkg::SY_HOT])
      ot_d = 1'b1;
    else if (sy_q[bmfc_pkg::SY_COOL])
      ot_d = 1'b0;
    if (!en_on)
    begin
      state_d = bmfc_pkg::ST_OFF;
      tmr_d   = 18'h00000;
    end
    else if (fault_any)
      state_d = bmfc_pkg::ST_LATCH;
    else
    begin
      unique case (state_q)
        bmfc_pkg::ST_OFF:
          state_d = bmfc_pkg::ST_REF;
        bmfc_pkg::ST_REF:
          if (sy_q[bmfc_pkg::SY_REF_OK] && !hold)
          begin
            state_d = bmfc_pkg::ST_PROG;
            tmr_d   = 18'h00000;
          end
        bmfc_pkg::ST_PROG:
        begin
          tre_sel_d = sy_q[bmfc_pkg::SY_TSEL1:bmfc_pkg::SY_TSEL0];
          oc_zero_d = sy_q[bmfc_pkg::SY_OCZERO];
          if (tmr_q == 18'(bmfc_pkg::PROG_CYC - 1))
          begin
            state_d = bmfc_pkg::ST_SOFT;
            tmr_d   = 18'h00000;
          end
          else
            tmr_d = tmr_q + 18'h00001;
        end
        bmfc_pkg::ST_SOFT:
          if (hold)
            state_d = bmfc_pkg::ST_REF;
          else if (tmr_q == 18'(SS_CYC - 1))
            state_d = bmfc_pkg::ST_RUN;
          else
            tmr_d = tmr_q + 18'h00001;
        bmfc_pkg::ST_RUN:
          if (hold)
            state_d = bmfc_pkg::ST_REF;
        bmfc_pkg::ST_LATCH:
          state_d = bmfc_pkg::ST_LATCH;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q   <= bmfc_pkg::ST_OFF;
      tmr_q     <= 18'h00000;
      tre_sel_q <= bmfc_pkg::TRE_SEL_DEFAULT;
      oc_zero_q <= 1'b0;
      ot_q      <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      tmr_q     <= tmr_d;
      tre_sel_q <= tre_sel_d;
      oc_zero_q <= oc_zero_d;
      ot_q      <= ot_d;
    end
  end

  logic sw_run;
  logic in_soft;
  logic fcont;
  logic tre_en;
  logic [8:0] count;
  logic wrap;
  logic boost_q;

  assign in_soft = (state_q == bmfc_pkg::ST_SOFT);
  assign sw_run  = in_soft || (state_q == bmfc_pkg::ST_RUN);
  assign fcont   = sw_run && (!mode_ps || in_soft);
  assign tre_en  = (tre_sel_q != bmfc_pkg::TRE_SEL_OFF);

  bmfc_sw_timer u_timer (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_run    (sw_run),
    .i_boost  (boost_q),
    .o_count  (count),
    .o_wrap   (wrap)
  );

  // Protection and per-cycle state
  logic       por;
  logic [8:0] oc_cnt_q;
  logic [8:0] oc_cnt_d;
  logic [8:0] ov_cnt_q;
  logic [8:0] ov_cnt_d;
  logic [8:0] uv_cnt_q;
  logic [8:0] uv_cnt_d;
  logic [8:0] bst_cnt_q;
  logic [8:0] bst_cnt_d;
  logic       oc_cut_q;
  logic       oc_cut_d;
  logic       f_oc_q;
  logic       f_oc_d;
  logic       f_ov_q;
  logic       f_ov_d;
  logic       f_uv_q;
  logic       f_uv_d;
  logic       ov_ls_q;
  logic       ov_ls_d;
  logic       zc_q;
  logic       zc_d;
  logic       skip_q;
  logic       skip_d;
  logic       boost_d;

  assign por       = (state_q == bmfc_pkg::ST_OFF);
  assign fault_any = f_oc_q || f_ov_q || f_uv_q;

  always_comb
  begin
    oc_cnt_d  = oc_cnt_q;
    ov_cnt_d  = ov_cnt_q;
    uv_cnt_d  = uv_cnt_q;
    bst_cnt_d = bst_cnt_q;
    oc_cut_d  = oc_cut_q || (sw_run && sy_q[bmfc_pkg::SY_OC]);
    f_oc_d    = f_oc_q;
    f_ov_d    = f_ov_q;
    f_uv_d    = f_uv_q;
    ov_ls_d   = ov_ls_q;
    zc_d      = zc_q || (sw_run && !fcont && sy_q[bmfc_pkg::SY_ZC] && o_ls_gate);
    skip_d    = skip_q;
    boost_d   = boost_q;
    if (wrap)
    begin
      // New cycle starts cut if the current is still over threshold
      oc_cut_d = sy_q[bmfc_pkg::SY_OC];
      oc_cnt_d = oc_cut_q ? sat_inc(oc_cnt_q) : 9'h000;
      if (oc_cnt_d >= 9'(bmfc_pkg::OC_LATCH_CYCLES))
        f_oc_d = 1'b1;
      if (state_q == bmfc_pkg::ST_RUN)
      begin
        uv_cnt_d = sy_q[bmfc_pkg::SY_UV_LO] ? sat_inc(uv_cnt_q) : 9'h000;
        if (uv_cnt_d >= 9'(bmfc_pkg::UV_LATCH_CYCLES))
          f_uv_d = 1'b1;
      end
      zc_d   = 1'b0;
      skip_d = !fcont && sy_q[bmfc_pkg::SY_LIGHT];
    end
    // Overvoltage blanking counted in clock cycles
    if (sw_run && sy_q[bmfc_pkg::SY_OV])
    begin
      if (ov_cnt_q >= 9'(bmfc_pkg::OV_BLANK_CYC))
      begin
        f_ov_d  = 1'b1;
        ov_ls_d = 1'b1;
      end
      ov_cnt_d = sat_inc(ov_cnt_q);
    end
    else
      ov_cnt_d = 9'h000;
    if (f_ov_q)
    begin
      if (sy_q[bmfc_pkg::SY_UV_HI])
        ov_ls_d = 1'b1;
      else if (sy_q[bmfc_pkg::SY_UV_LO])
        ov_ls_d = 1'b0;
    end
    // Boost lasts one normal switching period, only in continuous conduction
    if (bst_cnt_q != 9'h000)
      bst_cnt_d = bst_cnt_q - 9'h001;
    else if (sw_run && tre_en && !zc_q && sy_q[bmfc_pkg::SY_TRE])
      bst_cnt_d = 9'(bmfc_pkg::SW_PERIOD_CYC);
    boost_d = (bst_cnt_d != 9'h000);
    if (por)
    begin
      oc_cnt_d  = 9'h000;
      uv_cnt_d  = 9'h000;
      bst_cnt_d = 9'h000;
      boost_d   = 1'b0;
      f_oc_d    = 1'b0;
      f_ov_d    = 1'b0;
      f_uv_d    = 1'b0;
      ov_ls_d   = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      oc_cnt_q  <= 9'h000;
      ov_cnt_q  <= 9'h000;
      uv_cnt_q  <= 9'h000;
      bst_cnt_q <= 9'h000;
      oc_cut_q  <= 1'b0;
      f_oc_q    <= 1'b0;
      f_ov_q    <= 1'b0;
      f_uv_q    <= 1'b0;
      ov_ls_q   <= 1'b0;
      zc_q      <= 1'b0;
      skip_q    <= 1'b0;
      boost_q   <= 1'b0;
    end
    else
    begin
      oc_cnt_q  <= oc_cnt_d;
      ov_cnt_q  <= ov_cnt_d;
      uv_cnt_q  <= uv_cnt_d;
      bst_cnt_q <= bst_cnt_d;
      oc_cut_q  <= oc_cut_d;
      f_oc_q    <= f_oc_d;
      f_ov_q    <= f_ov_d;
      f_uv_q    <= f_uv_d;
      ov_ls_q   <= ov_ls_d;
      zc_q      <= zc_d;
      skip_q    <= skip_d;
      boost_q   <= boost_d;
    end
  end

  // Gate commands and status
  logic hs_q;
  logic hs_d;
  logic ls_q;
  logic ls_d;
  logic pg_q;
  logic pg_d;
  logic sg_q;
  logic sg_d;

  always_comb
  begin
    hs_d = sw_run && (count < i_on_time) && !oc_cut_d && !skip_q && !fault_any;
    ls_d = 1'b0;
    if (f_ov_q)
    begin
      hs_d = 1'b0;
      ls_d = ov_ls_q;
    end
    else if (fault_any || !sw_run)
      hs_d = 1'b0;
    else if (fcont)
      ls_d = !hs_d;
    else
      ls_d = !hs_d && !zc_d;
    pg_d = en_on && (state_q == bmfc_pkg::ST_RUN) && !fault_any && !hold;
    sg_d = o_uv_monitor_en && !uvlo;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      pg_q <= 1'b0;
      sg_q <= 1'b0;
    end
    else
    begin
      hs_q <= hs_d;
      ls_q <= ls_d;
      pg_q <= pg_d;
      sg_q <= sg_d;
    end
  end

  assign o_hs_gate                     = hs_q;
  assign o_ls_gate                     = ls_q;
  assign o_ref_en                      = (state_q != bmfc_pkg::ST_OFF);
  assign o_uv_monitor_en               = o_ref_en && (state_q != bmfc_pkg::ST_REF);
  assign o_supply_good                 = sg_q;
  assign o_power_good_out              = pg_q;
  assign o_transient_boost             = boost_q;
  assign o_forced_continuous_mode      = fcont;
  assign o_soft_start                  = in_soft;
  assign o_tre_en                      = tre_en;
  assign o_transient_boost_threshold   = (tre_sel_q == bmfc_pkg::TRE_SEL_ALT) ?
                                         bmfc_pkg::TRANSIENT_BOOST_THRESHOLD_ALT_MV :
                                         bmfc_pkg::TRANSIENT_BOOST_THRESHOLD_DEFAULT_MV;
  assign o_oc_default_sel              = oc_zero_q;
  assign o_overcurrent_sense_threshold = oc_zero_q ? bmfc_pkg::OC_TH_DEFAULT_MV : 10'h000;
  assign o_fault_oc                    = f_oc_q;
  assign o_fault_ov                    = f_ov_q;
  assign o_fault_uv                    = f_uv_q;
  assign o_temp_shutdown               = ot_q;
endmodule

// File: logic/bmfc_pkg.sv
// Constants and state type for the buck mode and fault controller
package bmfc_pkg;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned SW_PERIOD_NS     = 2000;
  localparam int unsigned SW_PERIOD_CYC    = SW_PERIOD_NS * CLK_MHZ / 1000;
  localparam int unsigned BOOST_DIV        = 4;
  localparam int unsigned BOOST_PERIOD_CYC = SW_PERIOD_CYC / BOOST_DIV;
  localparam int unsigned OV_BLANK_NS      = 1500;
  localparam int unsigned OV_BLANK_CYC     = (OV_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PROG_NS          = 10000;
  localparam int unsigned PROG_CYC         = (PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SS_US            = 1000;
  localparam int unsigned SS_CYC           = SS_US * CLK_MHZ;
  localparam int unsigned OC_LATCH_CYCLES  = 16;
  localparam int unsigned UV_LATCH_CYCLES  = 8;

  localparam logic [9:0] TRANSIENT_BOOST_THRESHOLD_DEFAULT_MV = 10'h12C;
  localparam logic [9:0] TRANSIENT_BOOST_THRESHOLD_ALT_MV     = 10'h1F4;
  localparam logic [9:0] OC_TH_DEFAULT_MV  = 10'h028;
  localparam logic [1:0] TRE_SEL_DEFAULT   = 2'h0;
  localparam logic [1:0] TRE_SEL_ALT       = 2'h1;
  localparam logic [1:0] TRE_SEL_OFF       = 2'h2;

  // Positions in the synchronised input vector
  localparam int unsigned SY_EN_DIS  = 0;
  localparam int unsigned SY_EN_SKIP = 1;
  localparam int unsigned SY_UVLO    = 2;
  localparam int unsigned SY_REF_OK  = 3;
  localparam int unsigned SY_OC      = 4;
  localparam int unsigned SY_OV      = 5;
  localparam int unsigned SY_UV_LO   = 6;
  localparam int unsigned SY_UV_HI   = 7;
  localparam int unsigned SY_TRE     = 8;
  localparam int unsigned SY_HOT     = 9;
  localparam int unsigned SY_COOL    = 10;
  localparam int unsigned SY_ZC      = 11;
  localparam int unsigned SY_LIGHT   = 12;
  localparam int unsigned SY_TSEL0   = 13;
  localparam int unsigned SY_TSEL1   = 14;
  localparam int unsigned SY_OCZERO  = 15;
  localparam int unsigned SY_W       = 16;

  typedef enum logic [2:0] {ST_OFF, ST_REF, ST_PROG, ST_SOFT, ST_RUN, ST_LATCH} bmfc_state_t;
endpackage

// File: logic/bmfc_sw_timer.sv
// Switching period counter with a shortened period while boosting
`timescale 1ns/10ps
module bmfc_sw_timer (
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  input  wire logic       i_run,
  input  wire logic       i_boost,
  output logic      [8:0] o_count,
  output logic            o_wrap
);
  logic [8:0] count_q;
  logic [8:0] count_d;
  logic [8:0] last;

  always_comb
  begin
    last = i_boost ? 9'(bmfc_pkg::BOOST_PERIOD_CYC - 1) : 9'(bmfc_pkg::SW_PERIOD_CYC - 1);
    // A boost starting mid-period ends the current period at once, or when the count reaches the shortened last count
    o_wrap = i_run && (count_q >= last);
    if (!i_run || o_wrap)
      count_d = 9'h000;
    else
      count_d = count_q + 9'h001;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      count_q <= 9'h000;
    else
      count_q <= count_d;
  end

  assign o_count = count_q;
endmodule
